// File: verilog/ddrc_defines.svh
/*
  timing counts, field values and mode word for the ddr host controller.
  assumes the memory clock runs at the link period below.
*/
`ifndef DDRC_DEFINES_SVH
`define DDRC_DEFINES_SVH
// ****************************************
// grade and clock
// ****************************************
`define DDRC_GRADE_FAST 1
// link period must stay 6..12 ns for the dll to lock
`define DDRC_LINK_PERIOD_PS 12000
// least times round up, longest round down
`define DDRC_CEIL(ns) ((((ns) * 1000) + `DDRC_LINK_PERIOD_PS - 1) / `DDRC_LINK_PERIOD_PS)
`define DDRC_FLOOR(ns) (((ns) * 1000) / `DDRC_LINK_PERIOD_PS)
// ****************************************
// times in ns
// ****************************************
`define DDRC_ROW_OPEN_NS (`DDRC_GRADE_FAST ? 42 : 45)
`define DDRC_ROW_CYCLE_NS (`DDRC_GRADE_FAST ? 60 : 65)
`define DDRC_REFRESH_CYCLE_NS (`DDRC_GRADE_FAST ? 72 : 75)
`define DDRC_ACT_ACCESS_NS (`DDRC_GRADE_FAST ? 18 : 20)
`define DDRC_PRECHARGE_NS (`DDRC_GRADE_FAST ? 18 : 20)
`define DDRC_BANK_GAP_NS (`DDRC_GRADE_FAST ? 12 : 15)
`define DDRC_WRITE_RECOVERY_NS 15
`define DDRC_REFRESH_INTERVAL_NS 7800
// ****************************************
// cycle figures
// ****************************************
`define DDRC_MODE_SET_GAP_CYC 2
`define DDRC_WRITE_TO_READ_GAP_CYC 1
`define DDRC_WRITE_DATA_LATENCY_CYC 1
`define DDRC_READ_LATENCY_CYC 3
`define DDRC_REF_MARGIN_CYC 16
// each term rounded up on its own before the sum
`define DDRC_AUTOCLOSE_CYC (`DDRC_CEIL(`DDRC_WRITE_RECOVERY_NS) + `DDRC_CEIL(`DDRC_PRECHARGE_NS))
// ****************************************
// fields
// ****************************************
`define DDRC_ADDR_BIT_TEN 10
`define DDRC_MODE_WORD 13'h0061
`endif

// File: verilog/ddrc_pkg.sv
/*
  types of the ddr host controller.
  assumes nothing beyond the defines header.
*/
package ddrc_pkg;
  // ras_n, cas_n, we_n
  typedef enum logic [2:0] {
    DDRC_NOP = 3'b111,
    DDRC_ACT = 3'b011,
    DDRC_RD = 3'b101,
    DDRC_WR = 3'b100,
    DDRC_PRE = 3'b010,
    DDRC_REF = 3'b001,
    DDRC_MRS = 3'b000
  } ddrc_cmd_t;
  typedef enum logic [2:0] {
    DDRC_S_INIT_PRE = 3'b000,
    DDRC_S_INIT_MRS = 3'b001,
    DDRC_S_IDLE = 3'b010,
    DDRC_S_ACCESS = 3'b011,
    DDRC_S_WAIT_DATA = 3'b100
  } ddrc_state_t;
endpackage : ddrc_pkg

// File: verilog/ddrc_host.sv
/*
  ddr host controller: one request at a time, closed page, two ranks.
  assumes link_clk is also the memory clock and an outside phy pairs
  the two beats of each clock onto the 16-bit data pins.
*/
// Contract
// - memory clock period between 6 and 12 ns
// - two cycles after mode set
// - row open 42/45 ns, closed before 120 us
// - same bank activate spacing 60/65 ns
// - refresh to next activate 72/75 ns
// - activate to access 18/20 ns
// - precharge to activate 18/20 ns
// - auto-close access no sooner than access delay
// - different bank activates 12/15 ns apart
// - write auto-close waits recovery plus precharge
// - round each term up before summing
// - read one cycle after write completes
// - average refresh interval at most 7.8 us
// - write strobe 0.75 to 1.25 cycles late
// - address bit ten selects close scope
// - write data one cycle after command
`include "ddrc_defines.svh"
module ddrc_host
  import ddrc_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic link_clk,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [25:0] req_addr,
  input wire logic [31:0] req_wdata,
  output logic resp_valid,
  output logic [31:0] resp_rdata,
  output logic mem_cke,
  output logic [1:0] mem_cs_n,
  output logic mem_ras_n,
  output logic mem_cas_n,
  output logic mem_we_n,
  output logic [1:0] mem_ba,
  output logic [12:0] mem_addr,
  input wire logic [31:0] mem_dq_i,
  output logic [31:0] mem_dq_o,
  output logic mem_dq_oe,
  output logic mem_dqs_o,
  output logic mem_dqs_oe
);
  localparam logic [3:0] RCD_CYC = 4'(`DDRC_CEIL(`DDRC_ACT_ACCESS_NS));
  localparam logic [3:0] RP_CYC = 4'(`DDRC_CEIL(`DDRC_PRECHARGE_NS));
  localparam logic [3:0] RC_CYC = 4'(`DDRC_CEIL(`DDRC_ROW_CYCLE_NS));
  localparam logic [3:0] RAS_CYC = 4'(`DDRC_CEIL(`DDRC_ROW_OPEN_NS));
  localparam logic [3:0] RFC_CYC = 4'(`DDRC_CEIL(`DDRC_REFRESH_CYCLE_NS));
  localparam logic [3:0] RRD_CYC = 4'(`DDRC_CEIL(`DDRC_BANK_GAP_NS));
  localparam logic [3:0] MRD_CYC = 4'(`DDRC_MODE_SET_GAP_CYC);
  localparam logic [3:0] DAL_CYC = 4'(`DDRC_AUTOCLOSE_CYC);
  localparam logic [3:0] WTR_CYC = 4'(`DDRC_WRITE_TO_READ_GAP_CYC + 2);
  localparam logic [3:0] RDW_CYC = 4'(`DDRC_READ_LATENCY_CYC + 2);
  localparam logic [3:0] WRW_CYC = 4'(`DDRC_WRITE_DATA_LATENCY_CYC + 1);
  localparam logic [9:0] REF_CYC = 10'(`DDRC_FLOOR(`DDRC_REFRESH_INTERVAL_NS));
  localparam logic [9:0] REF_DUE = 10'(`DDRC_FLOOR(`DDRC_REFRESH_INTERVAL_NS) - `DDRC_REF_MARGIN_CYC);
  // ****************************************
  // user side, clock domain
  // ****************************************
  logic req_tgl;
  logic hold_write;
  logic [25:0] hold_addr;
  logic [31:0] hold_wdata;
  logic done_s1;
  logic done_s2;
  logic done_seen;
  logic done_tgl;
  logic [31:0] rd_hold;
  // hold registers stay still until done returns, so words cross safely
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      req_ready <= 1'b1;
      req_tgl <= 1'b0;
      resp_valid <= 1'b0;
      resp_rdata <= 32'h0;
      done_seen <= 1'b0;
      hold_write <= 1'b0;
      hold_addr <= 26'h0;
      hold_wdata <= 32'h0;
    end
    else
    begin
      resp_valid <= 1'b0;
      if (req_valid && req_ready)
      begin
        hold_write <= req_write;
        hold_addr <= req_addr;
        hold_wdata <= req_wdata;
        req_tgl <= ~req_tgl;
        req_ready <= 1'b0;
      end
      if (done_s2 != done_seen)
      begin
        done_seen <= done_s2;
        resp_valid <= 1'b1;
        resp_rdata <= rd_hold;
        req_ready <= 1'b1;
      end
    end
  end
  always_ff @(posedge clock)
  begin
    done_s1 <= done_tgl;
    done_s2 <= done_s1;
  end
  // ****************************************
  // link side crossings
  // ****************************************
  logic [1:0] lrst_sync;
  logic lrst_n;
  logic req_s1;
  logic req_s2;
  logic req_seen;
  logic [31:0] dq_s1;
  logic [31:0] dq_s2;
  always_ff @(posedge link_clk)
  begin
    lrst_sync <= {lrst_sync[0], rstn};
    req_s1 <= req_tgl;
    req_s2 <= req_s1;
    dq_s1 <= mem_dq_i;
    dq_s2 <= dq_s1;
  end
  assign lrst_n = lrst_sync[1];
  // ****************************************
  // bank timers
  // ****************************************
  ddrc_state_t state;
  logic [3:0] wait_cnt;
  logic [3:0] rrd_cnt;
  logic [3:0] wtr_cnt;
  logic [9:0] ref_cnt;
  logic [3:0] bank_tmr [8];
  logic [7:0] busy;
  logic [2:0] sel;
  logic pending;
  logic ref_due;
  logic can_ref;
  logic can_act;
  logic can_acc;
  logic [3:0] want;
  logic [3:0] load_val;
  assign sel = hold_addr[25:23];
  assign pending = req_s2 != req_seen;
  assign ref_due = ref_cnt >= REF_DUE;
  assign can_ref = state == DDRC_S_IDLE && wait_cnt == 4'h0 && ref_due && busy == 8'h0;
  assign can_act = state == DDRC_S_IDLE && wait_cnt == 4'h0 && !ref_due && pending
                   && bank_tmr[sel] == 4'h0 && rrd_cnt == 4'h0;
  assign can_acc = state == DDRC_S_ACCESS && wait_cnt == 4'h0 && (hold_write || wtr_cnt == 4'h0);
  always_comb
  begin
    want = RC_CYC - 4'h1;
    if (can_acc)
    begin
      // the device closes the row itself once it has been open long enough
      want = hold_write ? DAL_CYC + 4'h1 : RAS_CYC + RP_CYC - RCD_CYC;
    end
    load_val = bank_tmr[sel] > want ? bank_tmr[sel] : want;
  end
  genvar g;
  for (g = 0; g < 8; g++)
  begin : g_bank
    assign busy[g] = bank_tmr[g] != 4'h0;
    always_ff @(posedge link_clk)
    begin
      if (!lrst_n)
      begin
        bank_tmr[g] <= 4'h0;
      end
      else if ((can_act || can_acc) && sel == 3'(g))
      begin
        bank_tmr[g] <= load_val;
      end
      else if (busy[g])
      begin
        bank_tmr[g] <= bank_tmr[g] - 4'h1;
      end
    end
  end
  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge link_clk)
  begin
    if (!lrst_n)
    begin
      state <= DDRC_S_INIT_PRE;
      wait_cnt <= 4'h0;
      req_seen <= 1'b0;
      done_tgl <= 1'b0;
      rd_hold <= 32'h0;
    end
    else
    begin
      if (wait_cnt != 4'h0)
      begin
        wait_cnt <= wait_cnt - 4'h1;
      end
      case (state)
        DDRC_S_INIT_PRE:
          if (wait_cnt == 4'h0)
          begin
            wait_cnt <= RP_CYC - 4'h1;
            state <= DDRC_S_INIT_MRS;
          end
        DDRC_S_INIT_MRS:
          if (wait_cnt == 4'h0)
          begin
            wait_cnt <= MRD_CYC - 4'h1;
            state <= DDRC_S_IDLE;
          end
        DDRC_S_IDLE:
          if (can_ref)
          begin
            wait_cnt <= RFC_CYC - 4'h1;
          end
          else if (can_act)
          begin
            req_seen <= req_s2;
            wait_cnt <= RCD_CYC - 4'h1;
            state <= DDRC_S_ACCESS;
          end
        DDRC_S_ACCESS:
          if (can_acc)
          begin
            wait_cnt <= hold_write ? WRW_CYC : RDW_CYC;
            state <= DDRC_S_WAIT_DATA;
          end
        DDRC_S_WAIT_DATA:
          if (wait_cnt == 4'h0)
          begin
            if (!hold_write)
            begin
              rd_hold <= dq_s2;
            end
            done_tgl <= ~done_tgl;
            state <= DDRC_S_IDLE;
          end
        default:
          state <= DDRC_S_IDLE;
      endcase
    end
  end
  // ****************************************
  // spacing counters
  // ****************************************
  always_ff @(posedge link_clk)
  begin
    if (!lrst_n)
    begin
      rrd_cnt <= 4'h0;
      wtr_cnt <= 4'h0;
      ref_cnt <= 10'h0;
    end
    else
    begin
      rrd_cnt <= can_act ? RRD_CYC - 4'h1 : rrd_cnt - 4'(rrd_cnt != 4'h0);
      wtr_cnt <= can_acc && hold_write ? WTR_CYC : wtr_cnt - 4'(wtr_cnt != 4'h0);
      // margin covers one request in flight when refresh falls due
      ref_cnt <= can_ref ? 10'h0 : ref_cnt + 10'(ref_cnt != 10'h3ff);
    end
  end
  // ****************************************
  // command pins
  // ****************************************
  ddrc_cmd_t cmd;
  assign {mem_ras_n, mem_cas_n, mem_we_n} = cmd;
  always_ff @(posedge link_clk)
  begin
    if (!lrst_n)
    begin
      cmd <= DDRC_NOP;
      mem_cke <= 1'b0;
      mem_cs_n <= 2'b11;
      mem_ba <= 2'h0;
      mem_addr <= 13'h0;
    end
    else
    begin
      cmd <= DDRC_NOP;
      mem_cke <= 1'b1;
      mem_cs_n <= 2'b11;
      if (state == DDRC_S_INIT_PRE && wait_cnt == 4'h0)
      begin
        cmd <= DDRC_PRE;
        mem_cs_n <= 2'b00;
        mem_addr <= 13'h0400;
      end
      else if (state == DDRC_S_INIT_MRS && wait_cnt == 4'h0)
      begin
        cmd <= DDRC_MRS;
        mem_cs_n <= 2'b00;
        mem_ba <= 2'h0;
        mem_addr <= `DDRC_MODE_WORD;
      end
      else if (can_ref)
      begin
        cmd <= DDRC_REF;
        mem_cs_n <= 2'b00;
      end
      else if (can_act || can_acc)
      begin
        cmd <= can_act ? DDRC_ACT : (hold_write ? DDRC_WR : DDRC_RD);
        mem_cs_n <= hold_addr[25] ? 2'b01 : 2'b10;
        mem_ba <= hold_addr[24:23];
        // every access closes its row on its own
        mem_addr <= can_act ? hold_addr[22:10] : {2'b00, 1'b1, hold_addr[9:0]};
      end
    end
  end
  // ****************************************
  // write data and strobe
  // ****************************************
  always_ff @(posedge link_clk)
  begin
    if (!lrst_n)
    begin
      mem_dq_o <= 32'h0;
      mem_dq_oe <= 1'b0;
      mem_dqs_o <= 1'b0;
      mem_dqs_oe <= 1'b0;
    end
    else
    begin
      // one clock after the write reaches the pins
      mem_dq_oe <= cmd == DDRC_WR;
      mem_dqs_oe <= cmd == DDRC_WR;
      mem_dqs_o <= cmd == DDRC_WR;
      mem_dq_o <= cmd == DDRC_WR ? hold_wdata : 32'h0;
    end
  end
  // ****************************************
  // checks
  // ****************************************
  logic [9:0] since_act;
  logic [9:0] since_ref;
  logic [9:0] since_wr;
  always_ff @(posedge link_clk)
  begin
    if (!lrst_n)
    begin
      since_act <= 10'h3ff;
      since_ref <= 10'h3ff;
      since_wr <= 10'h3ff;
    end
    else
    begin
      since_act <= cmd == DDRC_ACT ? 10'h1 : since_act + 10'(since_act != 10'h3ff);
      since_ref <= cmd == DDRC_REF ? 10'h1 : since_ref + 10'(since_ref != 10'h3ff);
      since_wr <= cmd == DDRC_WR ? 10'h1 : since_wr + 10'(since_wr != 10'h3ff);
    end
  end
  default clocking @(posedge link_clk); endclocking
  default disable iff (!lrst_n);
  property p_mode_gap;
    cmd == DDRC_MRS |=> cmd == DDRC_NOP;
  endproperty
  a_mode_gap: assert property (p_mode_gap) else $error("command inside mode set gap");
  property p_act_access;
    cmd inside {DDRC_RD, DDRC_WR} |-> since_act >= 10'(RCD_CYC);
  endproperty
  a_act_access: assert property (p_act_access) else $error("access too soon after activate");
  property p_bank_gap;
    cmd == DDRC_ACT |-> since_act >= 10'(RRD_CYC);
  endproperty
  a_bank_gap: assert property (p_bank_gap) else $error("activates too close");
  property p_refresh_gap;
    cmd inside {DDRC_ACT, DDRC_REF} |-> since_ref >= 10'(RFC_CYC);
  endproperty
  a_refresh_gap: assert property (p_refresh_gap) else $error("command too soon after refresh");
  property p_refresh_row;
    cmd == DDRC_REF |-> since_act >= 10'(RC_CYC);
  endproperty
  a_refresh_row: assert property (p_refresh_row) else $error("refresh too soon after activate");
  property p_autoclose;
    cmd inside {DDRC_RD, DDRC_WR} |-> mem_addr[`DDRC_ADDR_BIT_TEN] && $countones(mem_cs_n) == 1;
  endproperty
  a_autoclose: assert property (p_autoclose) else $error("access without auto close");
  property p_write_data;
    cmd == DDRC_WR |=> mem_dq_oe && mem_dqs_oe && mem_dqs_o ##1 !mem_dq_oe;
  endproperty
  a_write_data: assert property (p_write_data) else $error("write data misplaced");
  property p_refresh_due;
    ref_cnt <= REF_CYC;
  endproperty
  a_refresh_due: assert property (p_refresh_due) else $error("refresh overdue");
  property p_read_after_write;
    cmd == DDRC_RD |-> since_wr >= 10'(WTR_CYC);
  endproperty
  a_read_after_write: assert property (p_read_after_write) else $error("read too soon after write");
  c_refresh: cover property (cmd == DDRC_REF);
  c_write: cover property (cmd == DDRC_WR ##1 mem_dq_oe);
  c_read: cover property (cmd == DDRC_RD);
  c_mode: cover property (cmd == DDRC_MRS);
endmodule : ddrc_host

// File: verification/ddrc_mem_model.sv
/*
  behavioural two-rank ddr memory: stores words, returns reads, counts spacing faults.
  assumes commands change on link_clk rising edges and a 12 ns link period.
*/
module ddrc_mem_model
  import ddrc_pkg::*;
(
  input wire logic link_clk,
  input wire logic mem_cke,
  input wire logic [1:0] mem_cs_n,
  input wire logic mem_ras_n,
  input wire logic mem_cas_n,
  input wire logic mem_we_n,
  input wire logic [1:0] mem_ba,
  input wire logic [12:0] mem_addr,
  input wire logic [31:0] mem_dq_o,
  input wire logic mem_dq_oe,
  input wire logic mem_dqs_o,
  input wire logic mem_dqs_oe,
  output logic [31:0] mem_dq_i,
  output int violations,
  output int refreshes
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // spacing in link cycles
  // ****************************************
  localparam int PER_PS = 12000;
  function automatic int cyc_of(input int ps);
    return (ps + PER_PS - 1) / PER_PS;
  endfunction : cyc_of
  localparam int RCD = cyc_of(18000);
  localparam int RP = cyc_of(18000);
  localparam int RC = cyc_of(60000);
  localparam int RAS = cyc_of(42000);
  localparam int RFC = cyc_of(72000);
  localparam int RRD = cyc_of(12000);
  localparam int DAL = cyc_of(15000) + RP;
  localparam int RAS_MAX = 120000000 / PER_PS;
  localparam int REF_MAX = 7800000 / PER_PS;
  // ****************************************
  // bank state
  // ****************************************
  int cyc = 0, mrs_t = -100, ref_t = 0, rrd_t = -100, wr_due = -100, wr_end = -100, rd_t = -100;
  int act_t [8];
  int ready_t [8];
  logic open_q [8];
  logic [12:0] row_q [8];
  logic armed = 1'b0;
  logic [25:0] key, wr_key;
  logic [31:0] rd_word;
  logic [2:0] b;
  ddrc_cmd_t cmd;
  realtime last_t = 0;
  logic [31:0] store [logic [25:0]];
  initial
  begin
    violations = 0;
    refreshes = 0;
    mem_dq_i = 32'h0;
    foreach (act_t[i])
    begin
      act_t[i] = -100;
      ready_t[i] = 0;
      open_q[i] = 1'b0;
    end
  end
  task automatic bad(input string s);
    violations++;
    $display("memory model: %s at link cycle %0d", s, cyc);
  endtask : bad
  // ****************************************
  // command decode and checks
  // ****************************************
  always @(posedge link_clk)
  begin
    cyc++;
    if (last_t > 0 && ($realtime - last_t > 12.001 || $realtime - last_t < 5.999)) bad("clock period");
    last_t = $realtime;
    cmd = ddrc_cmd_t'({mem_ras_n, mem_cas_n, mem_we_n});
    b = {mem_cs_n[0], mem_ba};
    key = {b, row_q[b], mem_addr[9:0]};
    if (mem_cke && mem_cs_n != 2'b11 && cmd != DDRC_NOP)
    begin
      if (cyc - mrs_t < 2) bad("mode set gap");
      case (cmd)
        DDRC_MRS:
        begin
          mrs_t = cyc;
          ref_t = cyc;
          armed = 1'b1;
        end
        DDRC_PRE:
          for (int i = 0; i < 8; i++)
            if (mem_addr[10] || i == b)
            begin
              open_q[i] = 1'b0;
              ready_t[i] = cyc + RP;
            end
        DDRC_REF:
        begin
          for (int i = 0; i < 8; i++)
          begin
            if (open_q[i] || cyc < ready_t[i] || cyc - act_t[i] < RC) bad("refresh too soon");
            ready_t[i] = cyc + RFC;
          end
          refreshes++;
          ref_t = cyc;
        end
        DDRC_ACT:
        begin
          if (open_q[b] || cyc < ready_t[b]) bad("activate before close");
          if (cyc - act_t[b] < RC || cyc - rrd_t < RRD) bad("activate spacing");
          open_q[b] = 1'b1;
          row_q[b] = mem_addr;
          act_t[b] = cyc;
          rrd_t = cyc;
        end
        default:
        begin
          if (!open_q[b] || cyc - act_t[b] < RCD) bad("access too soon");
          if (cmd == DDRC_RD)
          begin
            if (cyc - wr_end < 1) bad("read after write");
            rd_t = cyc;
            rd_word = store.exists(key) ? store[key] : 32'hc0de_0000 ^ {6'h00, key};
          end
          else
          begin
            wr_due = cyc + 1;
            wr_key = key;
            wr_end = cyc + 2;
          end
          if (mem_addr[10])
          begin
            open_q[b] = 1'b0;
            ready_t[b] = (cmd == DDRC_WR) ? cyc + 1 + DAL :
              ((cyc + 1 > act_t[b] + RAS) ? cyc + 1 : act_t[b] + RAS) + RP;
          end
        end
      endcase
    end
    if (cyc == wr_due)
    begin
      if (mem_dq_oe && mem_dqs_oe && mem_dqs_o) store[wr_key] = mem_dq_o;
      else bad("write data not on time");
    end
    else if (mem_dq_oe) bad("data driven outside a write");
    for (int i = 0; i < 8; i++)
      if (open_q[i] && cyc - act_t[i] > RAS_MAX) bad("row open too long");
    if (armed && cyc - ref_t > REF_MAX) bad("refresh overdue");
    // read window past latency; outside it the bus churns so stale data cannot match
    mem_dq_i <= (cyc - rd_t >= 2 && cyc - rd_t <= 7) ? rd_word : 32'h9e37_79b9 * 32'(cyc);
  end
endmodule : ddrc_mem_model

// File: verification/tb.sv
/*
  self-checking bench for the ddr host controller with a memory model.
  assumes 8 ns user clock and a free 12 ns link clock of unrelated phase.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, link_clk = 1'b0, rstn = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic [25:0] req_addr = 26'h0;
  logic [31:0] req_wdata = 32'h0;
  logic req_ready, resp_valid, mem_cke, mem_ras_n, mem_cas_n, mem_we_n, mem_dq_oe, mem_dqs_o, mem_dqs_oe;
  logic [31:0] resp_rdata, mem_dq_i, mem_dq_o;
  logic [1:0] mem_cs_n, mem_ba;
  logic [12:0] mem_addr;
  int mismatches = 0, comparisons = 0, cycles = 0, vio, refs;
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin mismatches++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
  initial forever #4 clock = ~clock;
  initial
  begin
    #3;
    forever #6 link_clk = ~link_clk;
  end
  ddrc_host uut (.clock(clock), .rstn(rstn), .link_clk(link_clk), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .resp_valid(resp_valid),
    .resp_rdata(resp_rdata), .mem_cke(mem_cke), .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n),
    .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n), .mem_ba(mem_ba), .mem_addr(mem_addr), .mem_dq_i(mem_dq_i),
    .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe), .mem_dqs_o(mem_dqs_o), .mem_dqs_oe(mem_dqs_oe));
  ddrc_mem_model mem (.link_clk(link_clk), .mem_cke(mem_cke), .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n),
    .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n), .mem_ba(mem_ba), .mem_addr(mem_addr), .mem_dq_o(mem_dq_o),
    .mem_dq_oe(mem_dq_oe), .mem_dqs_o(mem_dqs_o), .mem_dqs_oe(mem_dqs_oe), .mem_dq_i(mem_dq_i),
    .violations(vio), .refreshes(refs));
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  // ****************************************
  // request driver, held until taken
  // ****************************************
  task automatic access(input logic wr, input logic [25:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clock);
    req_write <= wr;
    req_addr <= a;
    req_wdata <= d;
    req_valid <= 1'b1;
    n = 0;
    do begin @(posedge clock); n++; end while (req_ready !== 1'b1 && n < 400);
    req_valid <= 1'b0;
    n = 0;
    do begin @(posedge clock); n++; end while (resp_valid !== 1'b1 && n < 400);
    `CHK("resp_valid", 1'b1, resp_valid)
    q = resp_rdata;
  endtask : access
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    repeat (6) @(posedge clock);
    `CHK("req_ready in reset", 1'b1, req_ready)
    `CHK("resp_valid in reset", 1'b0, resp_valid)
    `CHK("mem_cke in reset", 1'b0, mem_cke)
    `CHK("mem_cs_n in reset", 2'b11, mem_cs_n)
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    $display("test reset done");
  endtask : t_reset
  task automatic t_write_read();
    logic [31:0] q;
    access(1'b1, {1'b0, 2'd1, 13'h0012, 10'h034}, 32'h1234_5678, q);
    access(1'b0, {1'b0, 2'd1, 13'h0012, 10'h034}, 32'h0, q);
    `CHK("read after write", 32'h1234_5678, q)
    `CHK("spacing faults", 0, vio)
    $display("test write_read done");
  endtask : t_write_read
  task automatic t_banks();
    logic [31:0] q;
    logic [25:0] adr [4] = '{{1'b0, 2'd0, 13'h0000, 10'h000}, {1'b0, 2'd0, 13'h0001, 10'h3ff},
      {1'b1, 2'd3, 13'h1fff, 10'h3ff}, {1'b1, 2'd3, 13'h1fff, 10'h001}};
    for (int i = 0; i < 4; i++) access(1'b1, adr[i], 32'ha5a5_0000 + 32'(i), q);
    for (int i = 0; i < 4; i++)
    begin
      access(1'b0, adr[i], 32'h0, q);
      `CHK("bank read", 32'ha5a5_0000 + 32'(i), q)
    end
    `CHK("spacing faults", 0, vio)
    $display("test banks done");
  endtask : t_banks
  task automatic t_fresh_read();
    logic [31:0] q;
    access(1'b0, {1'b1, 2'd2, 13'h0abc, 10'h155}, 32'h0, q);
    `CHK("unwritten read", 32'hc0de_0000 ^ {6'h00, 1'b1, 2'd2, 13'h0abc, 10'h155}, q)
    $display("test fresh_read done");
  endtask : t_fresh_read
  task automatic t_refresh();
    logic [31:0] q;
    int r0;
    r0 = refs;
    // 2000 user cycles span two refresh intervals of the link
    repeat (2000) @(posedge clock);
    `CHK("refresh count", 1'b1, (refs - r0 >= 2))
    access(1'b1, {1'b0, 2'd2, 13'h0777, 10'h0aa}, 32'h0f0f_3c3c, q);
    access(1'b0, {1'b0, 2'd2, 13'h0777, 10'h0aa}, 32'h0, q);
    `CHK("read near refresh", 32'h0f0f_3c3c, q)
    `CHK("spacing faults", 0, vio)
    $display("test refresh done");
  endtask : t_refresh
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 12000)
    begin
      mismatches++;
      $display("timeout after %0d cycles", cycles);
      close_out();
    end
  end
  initial
  begin
    t_reset();
    t_write_read();
    t_banks();
    t_fresh_read();
    t_refresh();
    close_out();
  end
endmodule : tb
